/* File: verilog/aee_event_data_encoder.sv */
`timescale 1ns/1ps
// Behaviour
// (RL1) temperature records carry sensor type 01h and event type 01h
// (RL2) above upper threshold: offset 09h, asserted
// (RL3) rising into middle band: offset 07h
// (RL4) falling back into middle band: offset 06h, deasserted
// (RL5) below lower threshold: offset 00h, deasserted
// (RL6) temperature offsets 08h and 01h are never produced
// (RL7) every full record (byte count 0Ah) carries source type 68h
// (RL8) sensor device field is the address given by address resolution
// (RL9) temperature sensor numbers 0Dh-0Fh; 00h and FFh never used
// (RL10) programmable temperature entity ids, defaults 07h, 03h, 03h
// (RL11) programmable temperature entity instances, defaults 01h, 01h, 02h
// (RL12) temperature event status indices 0Ch, 0Dh, 0Eh
// (RL13) deasserted status 02h, asserted 03h, both with byte count 0Ah
// (RL14) index beyond last valid: status 07h, byte count 02h, transfer ends
// (RL15) temperature severity 01h low, 08h middle, 10h high
// (RL16) voltage records carry sensor type 02h and event type 07h
// (RL17) voltage out of limits: offset 02h asserted; within: 07h deasserted
// (RL18) voltage sensor numbers 01h-09h in fixed channel order
// (RL19) voltage event status indices 00h-08h in the same order
// (RL20) programmable voltage entity ids, defaults 03h cores, 07h board inputs
// (RL21) voltage entity instances default 01h, 02h cores, 01h-07h board inputs
// (RL22) voltage severity 01h within limits, 10h beyond
// (RL23) status request returns device identifier and interface code 0024h
// (RL24) record chosen by requested index from current comparison state
module aee_event_data_encoder
    import aee_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h1234,  // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5678   // arbitrary value
) (
    input  wire logic                clock,             // 100 MHz system clock
    input  wire logic                sys_rst,           // async reset, active high
    input  wire logic                req_valid,         // record request pulse
    input  wire logic [7:0]          req_index,         // requested event status index
    input  wire logic [NUM_TEMP-1:0] temp_above_upper,  // temp over upper threshold
    input  wire logic [NUM_TEMP-1:0] temp_above_lower,  // temp over lower threshold
    input  wire logic [NUM_VOLT-1:0] volt_out_of_limit, // voltage beyond either limit
    input  wire logic [7:0]          arp_address,       // address from address resolution
    input  wire logic                cfg_we,            // entity write strobe
    input  wire logic [7:0]          cfg_index,         // event status index to program
    input  wire logic [7:0]          cfg_entity_id,     // new entity id
    input  wire logic [7:0]          cfg_entity_inst,   // new entity instance
    input  wire logic                status_req,        // identity request pulse
    output logic                     rsp_valid,         // record valid pulse
    output logic [7:0]               rsp_status,        // event status code
    output logic [7:0]               rsp_byte_count,    // response byte count
    output logic [7:0]               rsp_sensor_type,   // event sensor type
    output logic [7:0]               rsp_event_type,    // event type
    output logic [7:0]               rsp_event_offset,  // event offset
    output logic [7:0]               rsp_source_type,   // event source type
    output logic [7:0]               rsp_sensor_device, // sensor device address
    output logic [7:0]               rsp_sensor_number, // sensor number
    output logic [7:0]               rsp_entity_id,     // entity id
    output logic [7:0]               rsp_entity_inst,   // entity instance
    output logic [7:0]               rsp_severity,      // event severity
    output logic                     status_valid,      // identity valid pulse
    output logic [15:0]              status_vendor_id,  // vendor id
    output logic [15:0]              status_device_id,  // device id
    output logic [15:0]              status_interface   // protocol interface code
);

    // maps an event status index to a table slot; bit 4 flags a covered sensor
    function automatic logic [4:0] slot_of(input logic [7:0] idx);
        logic [7:0] tmp;
        tmp = 8'(idx - TEMP_IDX_FIRST);
        if (idx <= VOLT_IDX_LAST) begin
            slot_of = {1'b1, idx[3:0]};                           // see (RL19)
        end else if (idx >= TEMP_IDX_FIRST && idx <= TEMP_IDX_LAST) begin
            slot_of = {1'b1, 4'(TEMP_SLOT_BASE + tmp[3:0])};     // see (RL12)
        end else begin
            slot_of = 5'h00;
        end
    endfunction : slot_of

    logic [7:0]          ent_id   [NUM_SLOT];
    logic [7:0]          ent_inst [NUM_SLOT];
    logic [7:0]          next_ent_id   [NUM_SLOT];
    logic [7:0]          next_ent_inst [NUM_SLOT];
    logic [NUM_TEMP-1:0] from_above;
    logic [NUM_TEMP-1:0] next_from_above;
    logic [4:0]          cfg_slot;

    // entity table: software may retarget a sensor to another entity
    assign cfg_slot = slot_of(cfg_index);
    always_comb begin
        for (int s = 0; s < NUM_SLOT; s++) begin
            next_ent_id[s]   = ent_id[s];
            next_ent_inst[s] = ent_inst[s];
        end
        if (cfg_we && cfg_slot[4]) begin   // see (RL10) see (RL20)
            next_ent_id[cfg_slot[3:0]]   = cfg_entity_id;
            next_ent_inst[cfg_slot[3:0]] = cfg_entity_inst;   // see (RL11)
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int s = 0; s < NUM_SLOT; s++) begin
                ent_id[s]   <= ENT_ID_RST[s];     // see (RL10) see (RL20)
                ent_inst[s] <= ENT_INST_RST[s];   // see (RL11) see (RL21)
            end
        end else begin
            for (int s = 0; s < NUM_SLOT; s++) begin
                ent_id[s]   <= next_ent_id[s];
                ent_inst[s] <= next_ent_inst[s];
            end
        end
    end

    // direction memory: remembers whether the middle band was entered from above,
    // so the going-low offset is chosen without needing a second comparison
    always_comb begin
        for (int t = 0; t < NUM_TEMP; t++) begin
            if (temp_above_upper[t]) begin
                next_from_above[t] = 1'b1;
            end else if (!temp_above_lower[t]) begin
                next_from_above[t] = 1'b0;
            end else begin
                next_from_above[t] = from_above[t];
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            from_above <= '0;
        end else begin
            from_above <= next_from_above;
        end
    end

    logic [7:0] next_status, next_bc, next_stype, next_etype, next_ofs;
    logic [7:0] next_src, next_dev, next_snum, next_eid, next_einst, next_sev;
    logic [4:0] req_slot;
    logic [1:0] tch;

    // record assembly from the live comparison state of the selected sensor
    assign req_slot = slot_of(req_index);
    assign tch      = 2'(req_slot[3:0] - TEMP_SLOT_BASE);
    always_comb begin
        next_status = STAT_END;
        next_bc     = BC_SHORT;
        next_stype  = 8'h00;
        next_etype  = 8'h00;
        next_ofs    = 8'h00;
        next_src    = 8'h00;
        next_dev    = 8'h00;
        next_snum   = 8'h00;
        next_eid    = 8'h00;
        next_einst  = 8'h00;
        next_sev    = 8'h00;
        if (req_index > IDX_LIMIT) begin
            next_status = STAT_END;                              // see (RL14)
            next_bc     = BC_SHORT;
        end else if (!req_slot[4]) begin
            // sensors outside this block answer short so the walk can continue
            next_status = STAT_DISABLED;
            next_bc     = BC_SHORT;
        end else begin
            next_bc    = BC_FULL;                                // see (RL13)
            next_src   = SOURCE_TYPE;                            // see (RL7)
            next_dev   = arp_address;                            // see (RL8)
            next_snum  = 8'(req_index + SNUM_STEP);              // see (RL9) see (RL18)
            next_eid   = ent_id[req_slot[3:0]];                  // see (RL24)
            next_einst = ent_inst[req_slot[3:0]];
            if (req_slot[3:0] < TEMP_SLOT_BASE) begin
                next_stype = SENSOR_TYPE_VOLT;                   // see (RL16)
                next_etype = EVT_TYPE_GENERIC;
                if (volt_out_of_limit[req_slot[3:0]]) begin
                    next_ofs    = OFS_V_CRIT;                    // see (RL17)
                    next_status = STAT_ASSERT;
                    next_sev    = SEV_CRIT;                      // see (RL22)
                end else begin
                    next_ofs    = OFS_V_MON;
                    next_status = STAT_DEASSERT;
                    next_sev    = SEV_MONITOR;
                end
            end else begin
                next_stype = SENSOR_TYPE_TEMP;                   // see (RL1)
                next_etype = EVT_TYPE_THRESH;
                // only four offsets are reachable here, the two reserved ones never are
                if (temp_above_upper[tch]) begin
                    next_ofs    = OFS_UC_HIGH;                   // see (RL2) see (RL6)
                    next_status = STAT_ASSERT;
                    next_sev    = SEV_CRIT;                      // see (RL15)
                end else if (!temp_above_lower[tch]) begin
                    next_ofs    = OFS_LNC_LOW;                   // see (RL5)
                    next_status = STAT_DEASSERT;
                    next_sev    = SEV_MONITOR;
                end else if (from_above[tch]) begin
                    next_ofs    = OFS_UNC_LOW;                   // see (RL4)
                    next_status = STAT_DEASSERT;
                    next_sev    = SEV_NONCRIT;
                end else begin
                    next_ofs    = OFS_UNC_HIGH;                  // see (RL3)
                    next_status = STAT_ASSERT;
                    next_sev    = SEV_NONCRIT;
                end
            end
        end
    end

    // response registers: fields load only on a request and hold until the next
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid         <= 1'b0;
            rsp_status        <= 8'h00;
            rsp_byte_count    <= 8'h00;
            rsp_sensor_type   <= 8'h00;
            rsp_event_type    <= 8'h00;
            rsp_event_offset  <= 8'h00;
            rsp_source_type   <= 8'h00;
            rsp_sensor_device <= 8'h00;
            rsp_sensor_number <= 8'h00;
            rsp_entity_id     <= 8'h00;
            rsp_entity_inst   <= 8'h00;
            rsp_severity      <= 8'h00;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_status        <= next_status;
                rsp_byte_count    <= next_bc;
                rsp_sensor_type   <= next_stype;
                rsp_event_type    <= next_etype;
                rsp_event_offset  <= next_ofs;
                rsp_source_type   <= next_src;
                rsp_sensor_device <= next_dev;
                rsp_sensor_number <= next_snum;
                rsp_entity_id     <= next_eid;
                rsp_entity_inst   <= next_einst;
                rsp_severity      <= next_sev;
            end
        end
    end

    // identity answer; the three id outputs hold after a request so a late read still sees them, status_valid is a pulse
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_valid     <= 1'b0;
            status_vendor_id <= 16'h0000;
            status_device_id <= 16'h0000;
            status_interface <= 16'h0000;
        end else begin
            status_valid <= status_req;
            if (status_req) begin
                status_vendor_id <= VENDOR_ID;
                status_device_id <= DEVICE_ID;
                status_interface <= INTERFACE_CODE;              // see (RL23)
            end
        end
    end

    // any temperature request, so the over-upper and middle band checks follow whichever channel is walked
    logic req_temp;
    assign req_temp = req_valid && req_index >= TEMP_IDX_FIRST && req_index <= TEMP_IDX_LAST;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_TEMP_TYPE: assert property (req_valid && req_index == TEMP_IDX_FIRST |=> // see (RL1)
        rsp_sensor_type == SENSOR_TYPE_TEMP && rsp_event_type == EVT_TYPE_THRESH)
        else $error("temperature record type wrong");
    AST_TEMP_HIGH: assert property (req_temp // see (RL2)
        && temp_above_upper[tch] |=> rsp_event_offset == OFS_UC_HIGH
        && rsp_status == STAT_ASSERT && rsp_severity == SEV_CRIT)
        else $error("over-upper record wrong");
    AST_TEMP_RISE: assert property (req_temp // see (RL3)
        && temp_above_lower[tch] && !temp_above_upper[tch] && !from_above[tch]
        |=> rsp_event_offset == OFS_UNC_HIGH && rsp_severity == SEV_NONCRIT)
        else $error("middle band rising record wrong");
    AST_TEMP_FALL: assert property (req_temp // see (RL4)
        && temp_above_lower[tch] && !temp_above_upper[tch] && from_above[tch]
        |=> rsp_event_offset == OFS_UNC_LOW && rsp_status == STAT_DEASSERT)
        else $error("middle band falling record wrong");
    AST_TEMP_LOW: assert property (req_valid && req_index == TEMP_IDX_FIRST // see (RL5)
        && !temp_above_lower[0] && !temp_above_upper[0] |=> rsp_event_offset == OFS_LNC_LOW
        && rsp_status == STAT_DEASSERT && rsp_severity == SEV_MONITOR)
        else $error("under-lower record wrong");
    AST_NO_RESERVED: assert property (rsp_valid && rsp_sensor_type == SENSOR_TYPE_TEMP // see (RL6)
        |-> rsp_event_offset != OFS_UC_LOW && rsp_event_offset != OFS_LNC_HIGH)
        else $error("reserved temperature offset produced");
    AST_SOURCE: assert property (req_valid && req_slot[4] && req_index <= IDX_LIMIT // see (RL7)
        |=> rsp_source_type == SOURCE_TYPE && rsp_sensor_device == $past(arp_address)
        && rsp_byte_count == BC_FULL && rsp_sensor_number == $past(req_index) + SNUM_STEP)
        else $error("record header fields wrong");
    AST_END: assert property (req_valid && req_index > IDX_LIMIT // see (RL14)
        |=> rsp_valid && rsp_status == STAT_END && rsp_byte_count == BC_SHORT)
        else $error("end of walk not reported");
    AST_VOLT: assert property (req_valid && req_index <= VOLT_IDX_LAST // see (RL17)
        |=> rsp_sensor_type == SENSOR_TYPE_VOLT && rsp_event_type == EVT_TYPE_GENERIC
        && (rsp_status == STAT_ASSERT) == (rsp_severity == SEV_CRIT)
        && (rsp_event_offset == OFS_V_CRIT) == (rsp_status == STAT_ASSERT))
        else $error("voltage record inconsistent");
    AST_STATUS: assert property (status_req |=> status_valid // see (RL23)
        && status_interface == INTERFACE_CODE ##1 !status_valid || $past(status_req))
        else $error("identity answer wrong");

    COV_TEMP_HIGH: cover property (req_temp && temp_above_upper[tch]);
    COV_TEMP_FALL: cover property (rsp_valid && rsp_event_offset == OFS_UNC_LOW);
    COV_VOLT_CRIT: cover property (rsp_valid && rsp_sensor_type == SENSOR_TYPE_VOLT
        && rsp_status == STAT_ASSERT);
    COV_END: cover property (rsp_valid && rsp_status == STAT_END);

endmodule : aee_event_data_encoder

/* File: verilog/aee_pkg.sv */
package aee_pkg;
    // channel counts and table slots (voltage slots first, then temperature)
    localparam int NUM_VOLT = 9;
    localparam int NUM_TEMP = 3;
    localparam int NUM_SLOT = NUM_VOLT + NUM_TEMP;

    // event status index map
    localparam logic [7:0] VOLT_IDX_FIRST = 8'h00;
    localparam logic [7:0] VOLT_IDX_LAST  = 8'h08;
    localparam logic [7:0] TEMP_IDX_FIRST = 8'h0C;
    localparam logic [7:0] TEMP_IDX_LAST  = 8'h0E;
    localparam logic [7:0] IDX_LIMIT      = 8'h14;
    localparam logic [7:0] SNUM_STEP      = 8'h01;  // sensor number = index + 1
    localparam logic [3:0] TEMP_SLOT_BASE = 4'h9;

    // record type fields
    localparam logic [7:0] SENSOR_TYPE_TEMP = 8'h01;
    localparam logic [7:0] EVT_TYPE_THRESH  = 8'h01;
    localparam logic [7:0] SENSOR_TYPE_VOLT = 8'h02;
    localparam logic [7:0] EVT_TYPE_GENERIC = 8'h07;
    localparam logic [7:0] SOURCE_TYPE      = 8'h68;

    // event offsets
    localparam logic [7:0] OFS_UC_HIGH  = 8'h09;
    localparam logic [7:0] OFS_UC_LOW   = 8'h08;
    localparam logic [7:0] OFS_UNC_HIGH = 8'h07;
    localparam logic [7:0] OFS_UNC_LOW  = 8'h06;
    localparam logic [7:0] OFS_LNC_HIGH = 8'h01;
    localparam logic [7:0] OFS_LNC_LOW  = 8'h00;
    localparam logic [7:0] OFS_V_CRIT   = 8'h02;
    localparam logic [7:0] OFS_V_MON    = 8'h07;

    // status codes and byte counts
    localparam logic [7:0] STAT_DEASSERT = 8'h02;
    localparam logic [7:0] STAT_ASSERT   = 8'h03;
    localparam logic [7:0] STAT_DISABLED = 8'h04;
    localparam logic [7:0] STAT_END      = 8'h07;
    localparam logic [7:0] BC_FULL       = 8'h0A;
    localparam logic [7:0] BC_SHORT      = 8'h02;

    // severities
    localparam logic [7:0] SEV_MONITOR = 8'h01;
    localparam logic [7:0] SEV_NONCRIT = 8'h08;
    localparam logic [7:0] SEV_CRIT    = 8'h10;

    localparam logic [15:0] INTERFACE_CODE = 16'h0024;

    // entity defaults per slot: core a, core b, inputs 0-3, 5v, standby, battery, temp 1-3
    localparam logic [7:0] ENT_ID_RST [NUM_SLOT] = '{8'h03, 8'h03, 8'h07, 8'h07, 8'h07, 8'h07,
                                                     8'h07, 8'h07, 8'h07, 8'h07, 8'h03, 8'h03};
    localparam logic [7:0] ENT_INST_RST [NUM_SLOT] = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04,
                                                       8'h05, 8'h06, 8'h07, 8'h01, 8'h01, 8'h02};
endpackage : aee_pkg

/* File: tb/aee_host_model.sv */
`timescale 1ns/1ps
// management controller side: asks for event records and for the identity
module aee_host_model (
    input  wire logic       clock,      // system clock
    output logic            req_valid,  // record request pulse
    output logic [7:0]      req_index,  // requested event status index
    output logic            status_req  // identity request pulse
);
    // idle after time zero; no request before reset is gone
    initial begin
        req_valid  = 1'b0;
        req_index  = 8'h5A;
        status_req = 1'b0;
    end

    // one-cycle request on the falling edge so the rising edge sees it settled
    task automatic request(input logic [7:0] idx);
        @(negedge clock);
        req_valid = 1'b1;
        req_index = idx;
        @(negedge clock);
        req_valid = 1'b0;
        req_index = ~idx;  // a released index must not keep the old value
    endtask : request

    // identity query, one-cycle pulse
    task automatic identify();
        @(negedge clock);
        status_req = 1'b1;
        @(negedge clock);
        status_req = 1'b0;
    endtask : identify
endmodule : aee_host_model

/* File: tb/aee_event_data_encoder_tb.sv */
`timescale 1ns/1ps
module aee_event_data_encoder_tb;
    import aee_pkg::*;
    logic        clock, sys_rst, req_valid, cfg_we, status_req, rsp_valid, status_valid;
    logic [7:0]  req_index, arp_address, cfg_index, cfg_entity_id, cfg_entity_inst;
    logic [2:0]  temp_above_upper, temp_above_lower;
    logic [8:0]  volt_out_of_limit;
    logic [7:0]  rsp_status, rsp_byte_count, rsp_sensor_type, rsp_event_type, rsp_event_offset;
    logic [7:0]  rsp_source_type, rsp_sensor_device, rsp_sensor_number, rsp_entity_id;
    logic [7:0]  rsp_entity_inst, rsp_severity;
    logic [15:0] status_vendor_id, status_device_id, status_interface;
    int          err_count, comparisons;

    aee_host_model host (.clock(clock), .req_valid(req_valid), .req_index(req_index),
                         .status_req(status_req));
    aee_event_data_encoder #(.VENDOR_ID(16'h1234), .DEVICE_ID(16'h5678)) uut (
        .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_index(req_index),
        .temp_above_upper(temp_above_upper), .temp_above_lower(temp_above_lower),
        .volt_out_of_limit(volt_out_of_limit), .arp_address(arp_address), .cfg_we(cfg_we),
        .cfg_index(cfg_index), .cfg_entity_id(cfg_entity_id), .cfg_entity_inst(cfg_entity_inst),
        .status_req(status_req), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_byte_count(rsp_byte_count), .rsp_sensor_type(rsp_sensor_type),
        .rsp_event_type(rsp_event_type), .rsp_event_offset(rsp_event_offset),
        .rsp_source_type(rsp_source_type), .rsp_sensor_device(rsp_sensor_device),
        .rsp_sensor_number(rsp_sensor_number), .rsp_entity_id(rsp_entity_id),
        .rsp_entity_inst(rsp_entity_inst), .rsp_severity(rsp_severity),
        .status_valid(status_valid), .status_vendor_id(status_vendor_id),
        .status_device_id(status_device_id), .status_interface(status_interface));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    // one request, then every field; short answers carry zeros beyond the count
    task automatic ask(input logic [7:0] idx, st, et, ofs, stat, sev, sn, eid, ei);
        logic full;
        full = (stat == 8'h02) || (stat == 8'h03);
        host.request(idx);
        chk8("rsp_valid", 8'h01, {7'h00, rsp_valid});
        chk8("status", stat, rsp_status);
        chk8("byte_count", full ? 8'h0A : 8'h02, rsp_byte_count);
        chk8("sensor_type", st, rsp_sensor_type);
        chk8("event_type", et, rsp_event_type);
        chk8("event_offset", ofs, rsp_event_offset);
        chk8("source_type", full ? 8'h68 : 8'h00, rsp_source_type);
        chk8("sensor_device", full ? arp_address : 8'h00, rsp_sensor_device);
        chk8("sensor_number", sn, rsp_sensor_number);
        chk8("entity_id", eid, rsp_entity_id);
        chk8("entity_inst", ei, rsp_entity_inst);
        chk8("severity", sev, rsp_severity);
        @(negedge clock);
        chk8("rsp_valid_drop", 8'h00, {7'h00, rsp_valid});
    endtask : ask

    // every sensor in its quiet state, default entities
    task automatic t_defaults();
        logic [7:0] e, n;
        for (int i = 0; i < 9; i++) begin
            e = (i < 2) ? 8'h03 : 8'h07;
            n = (i < 2) ? 8'(i + 1) : 8'(i - 1);
            ask(8'(i), 8'h02, 8'h07, 8'h07, 8'h02, 8'h01, 8'(i + 1), e, n);
        end
        for (int c = 0; c < 3; c++) begin
            e = (c == 0) ? 8'h07 : 8'h03;
            n = (c == 2) ? 8'h02 : 8'h01;
            ask(8'h0C + 8'(c), 8'h01, 8'h01, 8'h00, 8'h02, 8'h01, 8'h0D + 8'(c), e, n);
        end
        $display("test defaults done");
    endtask : t_defaults

    // channel two walks up through both thresholds and back down
    task automatic t_temp_walk();
        @(negedge clock);
        temp_above_lower = 3'b010;
        ask(8'h0D, 8'h01, 8'h01, 8'h07, 8'h03, 8'h08, 8'h0E, 8'h03, 8'h01);
        temp_above_upper = 3'b010;
        ask(8'h0D, 8'h01, 8'h01, 8'h09, 8'h03, 8'h10, 8'h0E, 8'h03, 8'h01);
        temp_above_upper = 3'b000;
        ask(8'h0D, 8'h01, 8'h01, 8'h06, 8'h02, 8'h08, 8'h0E, 8'h03, 8'h01);
        temp_above_lower = 3'b000;
        ask(8'h0D, 8'h01, 8'h01, 8'h00, 8'h02, 8'h01, 8'h0E, 8'h03, 8'h01);
        $display("test temperature walk done");
    endtask : t_temp_walk

    // first and last voltage out of limits, a neighbour stays quiet
    task automatic t_volt_fault();
        @(negedge clock);
        volt_out_of_limit = 9'h101;
        ask(8'h00, 8'h02, 8'h07, 8'h02, 8'h03, 8'h10, 8'h01, 8'h03, 8'h01);
        ask(8'h08, 8'h02, 8'h07, 8'h02, 8'h03, 8'h10, 8'h09, 8'h07, 8'h07);
        ask(8'h01, 8'h02, 8'h07, 8'h07, 8'h02, 8'h01, 8'h02, 8'h03, 8'h02);
        volt_out_of_limit = 9'h000;
        $display("test voltage fault done");
    endtask : t_volt_fault

    // boundary indices: last valid, one past it, top of range, one gap
    task automatic t_end();
        ask(8'h14, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00);
        ask(8'h15, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00);
        ask(8'hFF, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00);
        ask(8'h0F, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test end of list done");
    endtask : t_end

    // reprogram one temperature and one voltage entity; a gap index is ignored
    task automatic t_entity();
        logic [7:0] idx [3] = '{8'h0E, 8'h05, 8'h0A};
        for (int k = 0; k < 3; k++) begin
            @(negedge clock);
            cfg_we = 1'b1;
            cfg_index = idx[k];
            cfg_entity_id = 8'hA0 + 8'(k);
            cfg_entity_inst = 8'hB0 + 8'(k);
        end
        @(negedge clock);
        cfg_we = 1'b0;
        ask(8'h0E, 8'h01, 8'h01, 8'h00, 8'h02, 8'h01, 8'h0F, 8'hA0, 8'hB0);
        ask(8'h05, 8'h02, 8'h07, 8'h07, 8'h02, 8'h01, 8'h06, 8'hA1, 8'hB1);
        ask(8'h0A, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00);
        ask(8'h00, 8'h02, 8'h07, 8'h07, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01);
        $display("test entity programming done");
    endtask : t_entity

    // identity answer
    task automatic t_identity();
        host.identify();
        chk8("status_valid", 8'h01, {7'h00, status_valid});
        chk16("interface", 16'h0024, status_interface);
        chk16("vendor_id", 16'h1234, status_vendor_id);
        chk16("device_id", 16'h5678, status_device_id);
        $display("test identity done");
    endtask : t_identity

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // reset held for 16 cycles, then every scenario in turn
    initial begin
        err_count = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        temp_above_upper = 3'b000;
        temp_above_lower = 3'b000;
        volt_out_of_limit = 9'h000;
        arp_address = 8'h4C;
        cfg_we = 1'b0;
        cfg_index = 8'h00;
        cfg_entity_id = 8'h00;
        cfg_entity_inst = 8'h00;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        chk8("rst_status", 8'h00, rsp_status);
        t_defaults();
        t_temp_walk();
        t_volt_fault();
        t_end();
        t_entity();
        t_identity();
        final_report();
    end
endmodule : aee_event_data_encoder_tb
